// ### core/timer16_count_compare_regs.sv
// Byte-wide register access to two 16-bit timer counts and their compare values
`timescale 1ns/1ps
`include "timer16_consts.svh"

// Overview of operation
// - Count readable and writable as two bytes
// - High byte access goes through staging register
// - One staging register shared by all registers
// - Count write blocks next tick's compare matches
// - Three compare values for unit1, two for unit3, reset zero
module timer16_count_compare_regs (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        count_tick_unit1,
    input  wire logic        count_tick_unit3,
    output logic      [15:0] count_unit1,
    output logic      [15:0] count_unit3,
    output logic      [4:0]  compare_match
);

    localparam int CH = `COMPARE_CHANNELS;

    // Channel order: unit1 A, B, C, then unit3 A, B
    localparam logic [7:0] CMP_LOW  [CH] = '{`ADDR_U1_COMPARE_A_LOW, `ADDR_U1_COMPARE_B_LOW,
                                             `ADDR_U1_COMPARE_C_LOW, `ADDR_U3_COMPARE_A_LOW,
                                             `ADDR_U3_COMPARE_B_LOW};
    localparam logic [7:0] CMP_HIGH [CH] = '{`ADDR_U1_COMPARE_A_HIGH, `ADDR_U1_COMPARE_B_HIGH,
                                             `ADDR_U1_COMPARE_C_HIGH, `ADDR_U3_COMPARE_A_HIGH,
                                             `ADDR_U3_COMPARE_B_HIGH};
    localparam logic [4:0] CH_UNIT3 = 5'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Access decode and staging register

    timer16_pkg::access_state_s s_q;
    timer16_pkg::access_state_s s_d;

    logic [15:0] cmp_val [CH];
    logic [CH-1:0] cmp_load;
    logic        cnt1_load;
    logic        cnt3_load;
    logic        blk1;
    logic        blk3;
    logic [15:0] commit_word;
    logic        hit_high;

    assign commit_word = {s_q.staging, reg_wdata};

    always_comb begin
        s_d       = s_q;
        cmp_load  = '0;
        cnt1_load = 1'b0;
        cnt3_load = 1'b0;
        hit_high  = (reg_addr == `ADDR_U1_COUNT_HIGH) || (reg_addr == `ADDR_U3_COUNT_HIGH);
        for (int i = 0; i < CH; i++) begin
            if (reg_addr == CMP_HIGH[i]) begin
                hit_high = 1'b1;
            end
        end
        if (reg_wr) begin
            // Any high byte write lands in the one shared staging register
            if (hit_high) begin
                s_d.staging = reg_wdata;
            end
            // Low byte write commits staged high byte with it
            cnt1_load = (reg_addr == `ADDR_U1_COUNT_LOW);
            cnt3_load = (reg_addr == `ADDR_U3_COUNT_LOW);
            for (int i = 0; i < CH; i++) begin
                cmp_load[i] = (reg_addr == CMP_LOW[i]);
            end
        end else if (reg_rd) begin
            s_d.rdata = `UNMAPPED_READ;
            if (hit_high) begin
                s_d.rdata = s_q.staging;
            end
            // Low byte read latches the high byte for the following high read
            if (reg_addr == `ADDR_U1_COUNT_LOW) begin
                s_d.rdata   = count_unit1[7:0];
                s_d.staging = count_unit1[15:8];
            end
            if (reg_addr == `ADDR_U3_COUNT_LOW) begin
                s_d.rdata   = count_unit3[7:0];
                s_d.staging = count_unit3[15:8];
            end
            for (int i = 0; i < CH; i++) begin
                if (reg_addr == CMP_LOW[i]) begin
                    s_d.rdata   = cmp_val[i][7:0];
                    s_d.staging = cmp_val[i][15:8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{staging: `RESET_BYTE, rdata: `RESET_BYTE};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Counts and compare channels

    timer16_count_unit #(
        .WIDTH (`COUNT_WIDTH)
    ) u_count1 (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .count_tick  (count_tick_unit1),
        .load        (cnt1_load),
        .load_value  (commit_word),
        .count_value (count_unit1),
        .block_match (blk1)
    );

    timer16_count_unit #(
        .WIDTH (`COUNT_WIDTH)
    ) u_count3 (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .count_tick  (count_tick_unit3),
        .load        (cnt3_load),
        .load_value  (commit_word),
        .count_value (count_unit3),
        .block_match (blk3)
    );

    for (genvar g = 0; g < CH; g++) begin : g_cmp
        // A tick that coincides with a count write is swallowed by the write
        timer16_compare_channel u_cmp (
            .clk_sys       (clk_sys),
            .rst_n         (rst_n),
            .load          (cmp_load[g]),
            .load_value    (commit_word),
            .count_value   (CH_UNIT3[g] ? count_unit3 : count_unit1),
            .count_tick    (CH_UNIT3[g] ? count_tick_unit3 : count_tick_unit1),
            .block_match   (CH_UNIT3[g] ? (blk3 | cnt3_load) : (blk1 | cnt1_load)),
            .compare_value (cmp_val[g]),
            .match         (compare_match[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_count_low_commit;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == `ADDR_U1_COUNT_LOW)
            |=> (count_unit1 == {$past(s_q.staging), $past(reg_wdata)});
    endproperty
    a_count_low_commit: assert property (p_count_low_commit)
        else $error("unit1 count did not take staged high and written low byte");

    property p_high_read_staging;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && !reg_wr && hit_high) |=> (reg_rdata == $past(s_q.staging));
    endproperty
    a_high_read_staging: assert property (p_high_read_staging)
        else $error("high byte read did not return the staging register");

    property p_shared_staging;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == `ADDR_U1_COMPARE_A_HIGH) ##1
        (reg_wr && reg_addr == `ADDR_U3_COUNT_LOW)
            |=> (count_unit3[15:8] == $past(reg_wdata, 2));
    endproperty
    a_shared_staging: assert property (p_shared_staging)
        else $error("staging register is not shared between registers");

    // Armed block or a write in the same cycle swallows the tick's matches
    property p_write_blocks_match;
        @(posedge clk_sys) disable iff (!rst_n)
        ((blk1 || cnt1_load) && count_tick_unit1) |=> (compare_match[2:0] == 3'h0);
    endproperty
    a_write_blocks_match: assert property (p_write_blocks_match)
        else $error("compare match not blocked on the tick after a count write");

    property p_block_flag;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == `ADDR_U3_COUNT_LOW) |=> blk3;
    endproperty
    a_block_flag: assert property (p_block_flag)
        else $error("count write did not arm the match block");

    property p_compare_commit;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == `ADDR_U3_COMPARE_B_LOW)
            |=> (cmp_val[4] == {$past(s_q.staging), $past(reg_wdata)});
    endproperty
    a_compare_commit: assert property (p_compare_commit)
        else $error("compare value did not take the committed word");

    property p_low_read_latch;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && !reg_wr && reg_addr == `ADDR_U3_COUNT_LOW)
            |=> (s_q.staging == $past(count_unit3[15:8])) && (reg_rdata == $past(count_unit3[7:0]));
    endproperty
    a_low_read_latch: assert property (p_low_read_latch)
        else $error("low byte read did not latch the high byte");

    property p_high_write_staging;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && hit_high) |=> (s_q.staging == $past(reg_wdata));
    endproperty
    a_high_write_staging: assert property (p_high_write_staging)
        else $error("high byte write did not land in the staging register");

    // Counting
    property p_u1_count_tick;
        @(posedge clk_sys) disable iff (!rst_n)
        (count_tick_unit1 && !cnt1_load) |=> (count_unit1 == $past(count_unit1) + 16'h0001);
    endproperty
    a_u1_count_tick: assert property (p_u1_count_tick)
        else $error("unit1 count did not advance on its tick");

    property p_u3_count_tick;
        @(posedge clk_sys) disable iff (!rst_n)
        (count_tick_unit3 && !cnt3_load) |=> (count_unit3 == $past(count_unit3) + 16'h0001);
    endproperty
    a_u3_count_tick: assert property (p_u3_count_tick)
        else $error("unit3 count did not advance on its tick");

    property p_u1_count_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (!count_tick_unit1 && !cnt1_load) |=> $stable(count_unit1);
    endproperty
    a_u1_count_hold: assert property (p_u1_count_hold)
        else $error("unit1 count moved without tick or write");

    property p_u3_count_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (!count_tick_unit3 && !cnt3_load) |=> $stable(count_unit3);
    endproperty
    a_u3_count_hold: assert property (p_u3_count_hold)
        else $error("unit3 count moved without tick or write");

    // Compare values and the match block
    property p_u3_write_blocks;
        @(posedge clk_sys) disable iff (!rst_n)
        ((blk3 || cnt3_load) && count_tick_unit3) |=> (compare_match[4:3] == 2'h0);
    endproperty
    a_u3_write_blocks: assert property (p_u3_write_blocks)
        else $error("unit3 match not blocked after a count write");

    property p_match_fires_u1;
        @(posedge clk_sys) disable iff (!rst_n)
        (count_tick_unit1 && !(blk1 || cnt1_load) && count_unit1 == cmp_val[0]) |=> compare_match[0];
    endproperty
    a_match_fires_u1: assert property (p_match_fires_u1)
        else $error("unit1 channel A missed an equal count");

    property p_match_fires_u3;
        @(posedge clk_sys) disable iff (!rst_n)
        (count_tick_unit3 && !(blk3 || cnt3_load) && count_unit3 == cmp_val[3]) |=> compare_match[3];
    endproperty
    a_match_fires_u3: assert property (p_match_fires_u3)
        else $error("unit3 channel A missed an equal count");

    property p_compare_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !cmp_load[0] |=> $stable(cmp_val[0]);
    endproperty
    a_compare_hold: assert property (p_compare_hold)
        else $error("compare value changed without a low byte write");

    // Scenarios worth seeing
    c_write_with_tick: cover property (@(posedge clk_sys) disable iff (!rst_n)
        cnt1_load && count_tick_unit1);

    c_count_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == `ADDR_U1_COUNT_LOW);
    c_match_unit3: cover property (@(posedge clk_sys) disable iff (!rst_n) compare_match[3]);
    c_word_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == `ADDR_U1_COMPARE_C_LOW) ##1 (reg_rd && reg_addr == `ADDR_U1_COMPARE_C_HIGH));

endmodule : timer16_count_compare_regs

// ### include/timer16_consts.svh
// Register offsets, reset values and widths of the timer count and compare register block
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

`define COUNT_WIDTH            16
`define BYTE_WIDTH             8
`define COMPARE_CHANNELS       5

`define ADDR_U1_COUNT_LOW      8'h2C
`define ADDR_U1_COUNT_HIGH     8'h2D
`define ADDR_U3_COUNT_LOW      8'h88
`define ADDR_U3_COUNT_HIGH     8'h89
`define ADDR_U1_COMPARE_A_LOW  8'h2A
`define ADDR_U1_COMPARE_A_HIGH 8'h2B
`define ADDR_U1_COMPARE_B_LOW  8'h28
`define ADDR_U1_COMPARE_B_HIGH 8'h29
`define ADDR_U1_COMPARE_C_LOW  8'h78
`define ADDR_U1_COMPARE_C_HIGH 8'h79
`define ADDR_U3_COMPARE_A_LOW  8'h86
`define ADDR_U3_COMPARE_A_HIGH 8'h87
`define ADDR_U3_COMPARE_B_LOW  8'h84
`define ADDR_U3_COMPARE_B_HIGH 8'h85

`define RESET_BYTE             8'h00
`define RESET_WORD             16'h0000
`define UNMAPPED_READ          8'h00

`endif

// ### include/timer16_pkg.sv
// State types of the timer count and compare register block
package timer16_pkg;

    typedef struct packed {
        logic [15:0] count;
        logic        block;
    } count_state_s;

    typedef struct packed {
        logic [15:0] value;
        logic        match;
    } compare_state_s;

    typedef struct packed {
        logic [7:0] staging;
        logic [7:0] rdata;
    } access_state_s;

endpackage : timer16_pkg

// ### core/timer16_count_unit.sv
// Running 16-bit count of one timer unit with the match block after a write
`timescale 1ns/1ps
`include "timer16_consts.svh"

module timer16_count_unit #(
    parameter int WIDTH = `COUNT_WIDTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        count_tick,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    output logic      [15:0] count_value,
    output logic             block_match
);

    if (WIDTH != `COUNT_WIDTH) begin : g_width_check
        $error("timer16_count_unit only serves a 16-bit count");
    end

    timer16_pkg::count_state_s s_q;
    timer16_pkg::count_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (load) begin
            // A written count also blocks the compare on the following tick
            s_d.count = load_value;
            s_d.block = 1'b1;
        end else if (count_tick) begin
            s_d.count = s_q.count + 16'h0001;
            s_d.block = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{count: `RESET_WORD, block: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign count_value = s_q.count;
    assign block_match = s_q.block;

endmodule : timer16_count_unit

// ### core/timer16_compare_channel.sv
// One 16-bit compare value with its registered match pulse
`timescale 1ns/1ps
`include "timer16_consts.svh"

module timer16_compare_channel (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    input  wire logic [15:0] count_value,
    input  wire logic        count_tick,
    input  wire logic        block_match,
    output logic      [15:0] compare_value,
    output logic             match
);

    timer16_pkg::compare_state_s s_q;
    timer16_pkg::compare_state_s s_d;

    always_comb begin
        s_d       = s_q;
        s_d.match = count_tick && !block_match && (count_value == s_q.value);
        if (load) begin
            s_d.value = load_value;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{value: `RESET_WORD, match: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign compare_value = s_q.value;
    assign match         = s_q.match;

endmodule : timer16_compare_channel

// ### tb/cpu_bus_model.sv
// Byte-wide CPU core model driving the timer register bus
`timescale 1ns/1ps

module cpu_bus_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe set at a falling edge; read data taken half a cycle after the taking edge
    task automatic access(input logic [7:0] addr, input logic wr, input logic [7:0] data,
                          output logic [7:0] rdata);
        reg_addr  = addr;
        reg_wr    = wr;
        reg_rd    = !wr;
        reg_wdata = wr ? data : ~data;
        @(negedge clk_sys);
        rdata     = reg_rdata;
    endtask : access

    // Released lines show inverted values so stale data is never mistaken for valid
    task automatic idle();
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(negedge clk_sys);
    endtask : idle

    task automatic write_word(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] value);
        logic [7:0] unused;
        access(hi, 1'b1, value[15:8], unused);
        access(lo, 1'b1, value[7:0], unused);
        idle();
    endtask : write_word

    task automatic read_word(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] value);
        access(lo, 1'b0, 8'h00, value[7:0]);
        access(hi, 1'b0, 8'h00, value[15:8]);
        idle();
    endtask : read_word
endmodule : cpu_bus_model

// ### tb/timer16_count_compare_regs_tb.sv
// Self-checking bench of the timer count and compare register block
`timescale 1ns/1ps
`include "timer16_consts.svh"

module timer16_count_compare_regs_tb;
    typedef struct packed {
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [15:0] val;
    } row_s;

    logic        clk_sys;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        count_tick_unit1;
    logic        count_tick_unit3;
    logic [15:0] count_unit1;
    logic [15:0] count_unit3;
    logic [4:0]  compare_match;
    int          n_fail;
    int          checked;
    int          cycles;
    logic [15:0] word;
    logic [7:0]  rd_byte;
    row_s        rows [8] = '{
        '{`ADDR_U1_COUNT_LOW,     `ADDR_U1_COUNT_HIGH,     16'h1234},
        '{`ADDR_U3_COUNT_LOW,     `ADDR_U3_COUNT_HIGH,     16'hA55A},
        '{`ADDR_U1_COMPARE_A_LOW, `ADDR_U1_COMPARE_A_HIGH, 16'h0F1E},
        '{`ADDR_U1_COMPARE_B_LOW, `ADDR_U1_COMPARE_B_HIGH, 16'h2D3C},
        '{`ADDR_U1_COMPARE_C_LOW, `ADDR_U1_COMPARE_C_HIGH, 16'hFFFF},
        '{`ADDR_U3_COMPARE_A_LOW, `ADDR_U3_COMPARE_A_HIGH, 16'h8001},
        '{`ADDR_U3_COMPARE_B_LOW, `ADDR_U3_COMPARE_B_HIGH, 16'h4B5A},
        '{`ADDR_U1_COUNT_LOW,     `ADDR_U1_COUNT_HIGH,     16'h7E81}
    };

    timer16_count_compare_regs dut (
        .clk_sys          (clk_sys),
        .reset_n          (reset_n),
        .reg_addr         (reg_addr),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_wdata        (reg_wdata),
        .reg_rdata        (reg_rdata),
        .count_tick_unit1 (count_tick_unit1),
        .count_tick_unit3 (count_tick_unit3),
        .count_unit1      (count_unit1),
        .count_unit3      (count_unit3),
        .compare_match    (compare_match)
    );

    cpu_bus_model cpu (
        .clk_sys   (clk_sys),
        .reg_rdata (reg_rdata),
        .reg_addr  (reg_addr),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_wdata (reg_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Tick pulse of one cycle; match is looked at in the cycle it stands
    task automatic tick(input logic t1, input logic t3, input logic [4:0] exp);
        count_tick_unit1 = t1;
        count_tick_unit3 = t3;
        @(negedge clk_sys);
        check("compare_match", {11'h000, compare_match}, {11'h000, exp});
        count_tick_unit1 = 1'b0;
        count_tick_unit3 = 1'b0;
        @(negedge clk_sys);
    endtask : tick

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n          = 1'b0;
        count_tick_unit1 = 1'b0;
        count_tick_unit3 = 1'b0;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            cpu.read_word(rows[i].lo, rows[i].hi, word);
            if (i < 7) check("reset word", word, `RESET_WORD);
            cpu.write_word(rows[i].lo, rows[i].hi, rows[i].val);
            cpu.read_word(rows[i].lo, rows[i].hi, word);
            check("word readback", word, rows[i].val);
        end
        check("count_unit1", count_unit1, rows[7].val);
        check("count_unit3", count_unit3, rows[1].val);
        cpu.access(8'h30, 1'b1, 8'h5A, rd_byte);
        cpu.access(8'h30, 1'b0, 8'h00, rd_byte);
        cpu.idle();
        check("unmapped read", {8'h00, rd_byte}, {8'h00, `UNMAPPED_READ});
        // High byte staged through a compare address lands in the unit3 count
        cpu.access(`ADDR_U1_COMPARE_A_HIGH, 1'b1, 8'hAB, rd_byte);
        cpu.access(`ADDR_U3_COUNT_LOW, 1'b1, 8'hCD, rd_byte);
        cpu.idle();
        check("shared staging write", count_unit3, 16'hABCD);
        cpu.read_word(`ADDR_U1_COMPARE_A_LOW, `ADDR_U1_COMPARE_A_HIGH, word);
        check("compare a untouched", word, rows[2].val);
        cpu.access(`ADDR_U1_COUNT_LOW, 1'b0, 8'h00, rd_byte);
        cpu.access(`ADDR_U3_COMPARE_B_HIGH, 1'b0, 8'h00, rd_byte);
        cpu.idle();
        check("shared staging read", {8'h00, rd_byte}, {8'h00, rows[7].val[15:8]});
        cpu.write_word(`ADDR_U1_COMPARE_A_LOW, `ADDR_U1_COMPARE_A_HIGH, 16'h0005);
        cpu.write_word(`ADDR_U3_COMPARE_A_LOW, `ADDR_U3_COMPARE_A_HIGH, 16'h0005);
        cpu.write_word(`ADDR_U1_COUNT_LOW, `ADDR_U1_COUNT_HIGH, 16'h0004);
        cpu.write_word(`ADDR_U3_COUNT_LOW, `ADDR_U3_COUNT_HIGH, 16'h0005);
        // Unit3 equal count right after a write is expected to be skipped
        tick(1'b1, 1'b1, 5'b00000);
        check("count_unit1 tick", count_unit1, 16'h0005);
        check("count_unit3 tick", count_unit3, 16'h0006);
        tick(1'b1, 1'b1, 5'b00001);
        cpu.write_word(`ADDR_U3_COUNT_LOW, `ADDR_U3_COUNT_HIGH, 16'h0004);
        tick(1'b0, 1'b1, 5'b00000);
        tick(1'b0, 1'b1, 5'b01000);
        // Tick in the same cycle as a count write is swallowed as well
        cpu.write_word(`ADDR_U1_COMPARE_A_LOW, `ADDR_U1_COMPARE_A_HIGH, 16'h0006);
        cpu.access(`ADDR_U1_COUNT_HIGH, 1'b1, 8'h00, rd_byte);
        count_tick_unit1 = 1'b1;
        cpu.access(`ADDR_U1_COUNT_LOW, 1'b1, 8'h05, rd_byte);
        count_tick_unit1 = 1'b0;
        check("match on write tick", {11'h000, compare_match}, 16'h0000);
        cpu.idle();
        check("count load wins", count_unit1, 16'h0005);
        tick(1'b1, 1'b0, 5'b00000);
        tick(1'b1, 1'b0, 5'b00001);
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("count_unit1 in reset", count_unit1, `RESET_WORD);
        check("count_unit3 in reset", count_unit3, `RESET_WORD);
        check("compare_match in reset", {11'h000, compare_match}, 16'h0000);
        reset_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        cpu.read_word(`ADDR_U3_COMPARE_A_LOW, `ADDR_U3_COMPARE_A_HIGH, word);
        check("compare after reset", word, `RESET_WORD);
        results();
    end
endmodule : timer16_count_compare_regs_tb
